/* rtl/ceau_branch_calc.v */
// Program-counter-relative target adder.
// Assumes the PC input already points at the instruction after the branch.
`timescale 1ns/1ps
module ceau_branch_calc (
  pc_next,
  disp,
  target
);
  input  wire [15:0] pc_next;
  input  wire [7:0]  disp;
  output wire [15:0] target;

  wire [15:0] disp_ext;

  assign disp_ext = {{8{disp[7]}}, disp};
  assign target   = pc_next + disp_ext;
endmodule // ceau_branch_calc

/* rtl/ceau_gpr_file.v */
// General register file of the effective-address unit.
// Assumes one update port from the address logic that wins over the execute-stage port.
`timescale 1ns/1ps
module ceau_gpr_file #(
  parameter NREG = 8,
  parameter SELW = 3
) (
  mclk,
  rst,
  ea_we,
  ea_sel,
  ea_data,
  ex_we,
  ex_sel,
  ex_data,
  rd_sel_a,
  rd_data_a,
  rd_sel_b,
  rd_data_b
);
  input  wire             mclk;
  input  wire             rst;
  input  wire             ea_we;
  input  wire [SELW-1:0]  ea_sel;
  input  wire [15:0]      ea_data;
  input  wire             ex_we;
  input  wire [SELW-1:0]  ex_sel;
  input  wire [15:0]      ex_data;
  input  wire [SELW-1:0]  rd_sel_a;
  output wire [15:0]      rd_data_a;
  input  wire [SELW-1:0]  rd_sel_b;
  output wire [15:0]      rd_data_b;

  reg  [15:0] gpr_r [0:NREG-1];
  genvar      g;

  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      always @(posedge mclk) begin
        if (rst) begin
          gpr_r[g] <= 16'h0000;
        end else if (ea_we && (ea_sel == g)) begin
          gpr_r[g] <= ea_data;
        end else if (ex_we && (ex_sel == g)) begin
          gpr_r[g] <= ex_data;
        end
      end
    end
  endgenerate

  assign rd_data_a = gpr_r[rd_sel_a];
  assign rd_data_b = gpr_r[rd_sel_b];
endmodule // ceau_gpr_file

/* rtl/ceau_map.vh */
// Constants for the CPU effective-address unit: mode codes, operation codes and field positions.
// Assumes it is included by bare name from the design file of ceau_unit, the only one of the unit that uses it.
// Behaviour
// - Post-increment reads at register address, then address_add_op 1 byte or 2 word.
// - Post-increment is accepted only for move loads from memory.
// - Pre-decrement subtracts 1 byte or 2 word; result is operand address.
// - The decremented value stays written back in the register.
// - Pre-decrement is accepted only for move stores to memory.
// - Absolute address comes straight from the instruction, 8 or 16 bits.
// - Short absolute is allowed only for byte moves and bit operations.
// - Long absolute is allowed for byte moves, word moves, jumps, subroutine jumps.
// - Short absolute forces the upper address byte to all ones.
// - Short immediate is byte two; long immediate is bytes three and four.
// - Long immediate is accepted only in word moves.
// - Address add and subtract carry an implicit immediate of 1 or 2.
// - Bit operations decode a 3-bit bit number from byte two or four.
// - Branch displacement in byte two is sign-extended and added to PC.
// - Relative targets span -126 to +129 bytes from the current address.
// - Memory-indirect reads a word at the short page address as destination.
`ifndef CEAU_MAP_VH
`define CEAU_MAP_VH
`define CEAU_MODE_POST_INC   3'h0
`define CEAU_MODE_PRE_DEC    3'h1
`define CEAU_MODE_SHORT_ABS  3'h2
`define CEAU_MODE_LONG_ABS   3'h3
`define CEAU_MODE_SHORT_IMM  3'h4
`define CEAU_MODE_LONG_IMM   3'h5
`define CEAU_MODE_PC_REL     3'h6
`define CEAU_MODE_MEM_IND    3'h7
`define CEAU_OP_BYTE_LOAD    4'h0
`define CEAU_OP_BYTE_STORE   4'h1
`define CEAU_OP_WORD_LOAD    4'h2
`define CEAU_OP_WORD_STORE   4'h3
`define CEAU_OP_BIT          4'h4
`define CEAU_OP_JUMP         4'h5
`define CEAU_OP_SUB_JUMP     4'h6
`define CEAU_OP_COND_BRANCH  4'h7
`define CEAU_OP_BR_SUB       4'h8
`define CEAU_OP_ADDR_ADD     4'h9
`define CEAU_OP_ADDR_SUB     4'ha
`define CEAU_PAGE_HI         8'hff
`define CEAU_STEP_BYTE       16'h0001
`define CEAU_STEP_WORD       16'h0002
`define CEAU_BITNUM_MSB      6
`define CEAU_BITNUM_LSB      4
`endif

/* rtl/ceau_unit.v */
// Effective-address unit between instruction decode and the byte-wide memory bus.
// Assumes decode holds request fields stable while req_valid is high and not yet taken.
`timescale 1ns/1ps
`include "ceau_map.vh"
module ceau_unit #(
  parameter NREG = 8,
  parameter SELW = 3
) (
  mclk,
  rst,
  req_valid,
  req_ready,
  req_mode,
  req_op,
  req_reg,
  req_two,
  req_bit_hi,
  instr_b2,
  instr_b3,
  instr_b4,
  pc_next,
  ex_we,
  ex_sel,
  ex_data,
  rd_sel,
  rd_data,
  mem_rd,
  mem_addr,
  mem_rdata,
  mem_ack,
  ea_valid,
  ea_addr,
  imm_valid,
  imm_data,
  bit_valid,
  bit_num,
  ea_illegal
);
  input  wire             mclk;
  input  wire             rst;
  input  wire             req_valid;
  output wire             req_ready;
  input  wire [2:0]       req_mode;
  input  wire [3:0]       req_op;
  input  wire [SELW-1:0]  req_reg;
  input  wire             req_two;
  input  wire             req_bit_hi;
  input  wire [7:0]       instr_b2;
  input  wire [7:0]       instr_b3;
  input  wire [7:0]       instr_b4;
  input  wire [15:0]      pc_next;
  input  wire             ex_we;
  input  wire [SELW-1:0]  ex_sel;
  input  wire [15:0]      ex_data;
  input  wire [SELW-1:0]  rd_sel;
  output wire [15:0]      rd_data;
  output wire             mem_rd;
  output reg  [15:0]      mem_addr;
  input  wire [7:0]       mem_rdata;
  input  wire             mem_ack;
  output reg              ea_valid;
  output reg  [15:0]      ea_addr;
  output reg              imm_valid;
  output reg  [15:0]      imm_data;
  output reg              bit_valid;
  output reg  [2:0]       bit_num;
  output reg              ea_illegal;

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_HI    = 3'b010;
  localparam [2:0] ST_LO    = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [7:0]  hi_byte_r;
  reg  [7:0]  hi_byte_nxt;
  reg  [15:0] mem_addr_nxt;
  reg         ea_valid_nxt;
  reg  [15:0] ea_addr_nxt;
  reg         imm_valid_nxt;
  reg  [15:0] imm_data_nxt;
  reg         bit_valid_nxt;
  reg  [2:0]  bit_num_nxt;
  reg         illegal_nxt;
  reg         gpr_we;
  reg  [15:0] gpr_wdata;
  reg         legal;
  reg         is_byte;
  reg         is_word;
  reg         is_load;
  reg         is_store;

  wire        take;
  wire [15:0] gpr_val;
  wire [15:0] step;
  wire [15:0] br_target;
  wire [15:0] page_addr;

  assign take      = req_valid && req_ready;
  assign req_ready = state_r[0];
  assign mem_rd    = state_r[1] || state_r[2];
  assign page_addr = {`CEAU_PAGE_HI, instr_b2};

  ceau_gpr_file #(
    .NREG (NREG),
    .SELW (SELW)
  ) u_gpr (
    .mclk      (mclk),
    .rst       (rst),
    .ea_we     (gpr_we),
    .ea_sel    (req_reg),
    .ea_data   (gpr_wdata),
    .ex_we     (ex_we),
    .ex_sel    (ex_sel),
    .ex_data   (ex_data),
    .rd_sel_a  (req_reg),
    .rd_data_a (gpr_val),
    .rd_sel_b  (rd_sel),
    .rd_data_b (rd_data)
  );

  ceau_branch_calc u_br (
    .pc_next (pc_next),
    .disp    (instr_b2),
    .target  (br_target)
  );

  // Step size follows the move width.
  assign step = is_word ? `CEAU_STEP_WORD : `CEAU_STEP_BYTE;

  always @* begin
    is_byte  = (req_op == `CEAU_OP_BYTE_LOAD) || (req_op == `CEAU_OP_BYTE_STORE);
    is_word  = (req_op == `CEAU_OP_WORD_LOAD) || (req_op == `CEAU_OP_WORD_STORE);
    is_load  = (req_op == `CEAU_OP_BYTE_LOAD) || (req_op == `CEAU_OP_WORD_LOAD);
    is_store = (req_op == `CEAU_OP_BYTE_STORE) || (req_op == `CEAU_OP_WORD_STORE);
  end

  // Legality of each mode against the operation.
  always @* begin
    legal = 1'b0;
    if ((req_op == `CEAU_OP_ADDR_ADD) || (req_op == `CEAU_OP_ADDR_SUB)) begin
      legal = 1'b1;
    end else begin
      case (req_mode)
        `CEAU_MODE_POST_INC: begin
          legal = is_load;
        end
        `CEAU_MODE_PRE_DEC: begin
          legal = is_store;
        end
        `CEAU_MODE_SHORT_ABS: begin
          legal = is_byte || (req_op == `CEAU_OP_BIT);
        end
        `CEAU_MODE_LONG_ABS: begin
          legal = is_byte || is_word || (req_op == `CEAU_OP_JUMP) ||
                  (req_op == `CEAU_OP_SUB_JUMP);
        end
        `CEAU_MODE_SHORT_IMM: begin
          legal = is_byte || is_word || (req_op == `CEAU_OP_BIT);
        end
        `CEAU_MODE_LONG_IMM: begin
          legal = is_word;
        end
        `CEAU_MODE_PC_REL: begin
          legal = (req_op == `CEAU_OP_COND_BRANCH) || (req_op == `CEAU_OP_BR_SUB);
        end
        `CEAU_MODE_MEM_IND: begin
          legal = (req_op == `CEAU_OP_JUMP) || (req_op == `CEAU_OP_SUB_JUMP);
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end
  end

  always @* begin
    state_nxt     = state_r;
    hi_byte_nxt   = hi_byte_r;
    mem_addr_nxt  = mem_addr;
    ea_valid_nxt  = 1'b0;
    ea_addr_nxt   = ea_addr;
    imm_valid_nxt = 1'b0;
    imm_data_nxt  = imm_data;
    bit_valid_nxt = 1'b0;
    bit_num_nxt   = bit_num;
    illegal_nxt   = 1'b0;
    gpr_we        = 1'b0;
    gpr_wdata     = gpr_val;
    case (state_r)
      ST_IDLE: begin
        if (take && !legal) begin
          illegal_nxt = 1'b1;
        end else if (take && (req_op == `CEAU_OP_ADDR_ADD ||
                              req_op == `CEAU_OP_ADDR_SUB)) begin
          imm_valid_nxt = 1'b1;
          imm_data_nxt  = req_two ? `CEAU_STEP_WORD : `CEAU_STEP_BYTE;
        end else if (take) begin
          if (req_op == `CEAU_OP_BIT) begin
            bit_valid_nxt = 1'b1;
            bit_num_nxt   = req_bit_hi ?
                            instr_b4[`CEAU_BITNUM_MSB:`CEAU_BITNUM_LSB] :
                            instr_b2[`CEAU_BITNUM_MSB:`CEAU_BITNUM_LSB];
          end
          case (req_mode)
            `CEAU_MODE_POST_INC: begin
              ea_valid_nxt = 1'b1;
              ea_addr_nxt  = gpr_val;
              gpr_we       = 1'b1;
              gpr_wdata    = gpr_val + step;
            end
            `CEAU_MODE_PRE_DEC: begin
              ea_valid_nxt = 1'b1;
              ea_addr_nxt  = gpr_val - step;
              gpr_we       = 1'b1;
              gpr_wdata    = gpr_val - step;
            end
            `CEAU_MODE_SHORT_ABS: begin
              ea_valid_nxt = 1'b1;
              ea_addr_nxt  = page_addr;
            end
            `CEAU_MODE_LONG_ABS: begin
              ea_valid_nxt = 1'b1;
              ea_addr_nxt  = {instr_b3, instr_b4};
            end
            `CEAU_MODE_SHORT_IMM: begin
              imm_valid_nxt = 1'b1;
              imm_data_nxt  = {8'h00, instr_b2};
            end
            `CEAU_MODE_LONG_IMM: begin
              imm_valid_nxt = 1'b1;
              imm_data_nxt  = {instr_b3, instr_b4};
            end
            `CEAU_MODE_PC_REL: begin
              ea_valid_nxt = 1'b1;
              ea_addr_nxt  = br_target;
            end
            `CEAU_MODE_MEM_IND: begin
              state_nxt    = ST_HI;
              mem_addr_nxt = page_addr;
            end
            default: begin
              illegal_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_HI: begin
        if (mem_ack) begin
          hi_byte_nxt  = mem_rdata;
          mem_addr_nxt = mem_addr + 16'h0001;
          state_nxt    = ST_LO;
        end
      end
      ST_LO: begin
        if (mem_ack) begin
          ea_valid_nxt = 1'b1;
          ea_addr_nxt  = {hi_byte_r, mem_rdata};
          state_nxt    = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      hi_byte_r  <= 8'h00;
      mem_addr   <= 16'h0000;
      ea_valid   <= 1'b0;
      ea_addr    <= 16'h0000;
      imm_valid  <= 1'b0;
      imm_data   <= 16'h0000;
      bit_valid  <= 1'b0;
      bit_num    <= 3'h0;
      ea_illegal <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      hi_byte_r  <= hi_byte_nxt;
      mem_addr   <= mem_addr_nxt;
      ea_valid   <= ea_valid_nxt;
      ea_addr    <= ea_addr_nxt;
      imm_valid  <= imm_valid_nxt;
      imm_data   <= imm_data_nxt;
      bit_valid  <= bit_valid_nxt;
      bit_num    <= bit_num_nxt;
      ea_illegal <= illegal_nxt;
    end
  end
endmodule // ceau_unit

/* tb/ceau_mem_model.sv */
// Byte memory answering fetch reads; each byte is its address low byte xor 5a.
// Assumes mem_rd is held until the acknowledge; slow address_add_op three wait cycles.
`timescale 1ns/1ps
module ceau_mem_model (
  input  wire        mclk,
  input  wire        slow,
  input  wire        mem_rd,
  input  wire [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  output logic       mem_ack
);
  logic [1:0] cnt_r;
  initial begin
    mem_rdata = 8'h00;
    mem_ack = 1'b0;
    cnt_r = 2'h0;
  end
  always @(posedge mclk) begin
    if (mem_rd && !mem_ack && cnt_r == {slow, slow}) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ 8'h5a;
      cnt_r <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd && !mem_ack)
        cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule // ceau_mem_model

/* tb/ceau_unit_properties.sv */
// Concurrent checks on the ports of the effective-address unit.
// Assumes the bench binds it to ceau_unit, one clock domain with synchronous reset.
`timescale 1ns/1ps
module ceau_unit_properties (
  input wire        mclk,
  input wire        rst,
  input wire        req_valid,
  input wire        req_ready,
  input wire [2:0]  req_mode,
  input wire [3:0]  req_op,
  input wire        req_two,
  input wire [7:0]  instr_b2,
  input wire [7:0]  instr_b3,
  input wire [7:0]  instr_b4,
  input wire [15:0] pc_next,
  input wire        mem_rd,
  input wire [15:0] mem_addr,
  input wire        ea_valid,
  input wire [15:0] ea_addr,
  input wire        imm_valid,
  input wire [15:0] imm_data,
  input wire        ea_illegal
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire       tk = req_valid && req_ready;
  wire [6:0] mo = {req_mode, req_op};
  wire       mi = tk && (mo == 7'h75 || mo == 7'h76);
  a_short_page:
    assert property (tk && mo == 7'h20 |=> ea_valid && ea_addr == {8'hff, $past(instr_b2)})
      else $error("short absolute page wrong");
  a_long_abs:
    assert property (tk && mo == 7'h35 |=> ea_valid
      && ea_addr == {$past(instr_b3), $past(instr_b4)}) else $error("long absolute wrong");
  a_pc_rel:
    assert property (tk && mo == 7'h67 |=> ea_addr == $past(pc_next)
      + {{8{$past(instr_b2[7])}}, $past(instr_b2)}) else $error("relative target wrong");
  a_mem_first:
    assert property (mi |=> mem_rd && mem_addr == {8'hff, $past(instr_b2)})
      else $error("indirect fetch address wrong");
  a_mem_bound:
    assert property (mi |-> ##[2:40] ea_valid) else $error("indirect target late");
  a_long_imm_only:
    assert property (tk && mo == 7'h50 |=> ea_illegal && !imm_valid)
      else $error("long immediate accepted");
  a_post_inc_only:
    assert property (tk && (mo == 7'h01 || mo == 7'h03) |=> ea_illegal && !ea_valid)
      else $error("post-increment store accepted");
  a_pre_dec_only:
    assert property (tk && (mo == 7'h10 || mo == 7'h12) |=> ea_illegal && !ea_valid)
      else $error("pre-decrement load accepted");
  a_short_only:
    assert property (tk && mo == 7'h25 |=> ea_illegal) else $error("short absolute jump");
  a_step_imm:
    assert property (tk && req_op == 4'h9 |=> imm_valid
      && imm_data == ($past(req_two) ? 16'h0002 : 16'h0001)) else $error("step wrong");
  cover property (mi);
  cover property (ea_illegal);
  cover property (tk && req_mode == 3'h0);
endmodule // ceau_unit_properties

/* tb/ceau_unit_test.sv */
// Self-checking bench for the effective-address unit.
// Assumes the checker and the memory model are compiled first.
`timescale 1ns/1ps
module ceau_unit_test;
  logic        mclk, rst, req_valid, req_two, req_bit_hi, ex_we, slow;
  logic [2:0]  req_mode, req_reg, ex_sel, rd_sel;
  logic [3:0]  req_op;
  logic [7:0]  instr_b2, instr_b3, instr_b4;
  logic [15:0] pc_next, ex_data;
  wire         req_ready, mem_rd, mem_ack, ea_valid, imm_valid, bit_valid, ea_illegal;
  wire  [15:0] rd_data, mem_addr, ea_addr, imm_data;
  wire  [7:0]  mem_rdata;
  wire  [2:0]  bit_num;
  wire  [3:0]  pl = {ea_valid, imm_valid, bit_valid, ea_illegal};
  int          err_count, n_tests;
  ceau_unit DUT (.mclk, .rst, .req_valid, .req_ready, .req_mode, .req_op, .req_reg, .req_two,
    .req_bit_hi, .instr_b2, .instr_b3, .instr_b4, .pc_next, .ex_we, .ex_sel, .ex_data,
    .rd_sel, .rd_data, .mem_rd, .mem_addr, .mem_rdata, .mem_ack, .ea_valid, .ea_addr,
    .imm_valid, .imm_data, .bit_valid, .bit_num, .ea_illegal);
  ceau_mem_model mem (.mclk, .slow, .mem_rd, .mem_addr, .mem_rdata, .mem_ack);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic got(input string nm, input [3:0] p, input [15:0] e, input [15:0] s);
    check({nm, " pulses"}, {12'h0, pl}, {12'h0, p});
    check(nm, s, e);
  endtask
  task automatic wr(input [2:0] s, input [15:0] d);
    @(posedge mclk);
    ex_we <= 1'b1;
    ex_sel <= s;
    ex_data <= d;
    @(posedge mclk);
    ex_we <= 1'b0;
  endtask
  task automatic rd(input [2:0] s, input [15:0] e);
    @(posedge mclk);
    rd_sel <= s;
    #1;
    check("register", rd_data, e);
  endtask
  task automatic req(input [2:0] m, input [3:0] o, input [2:0] r, input a, input [7:0] b2,
                     input [15:0] w);
    @(posedge mclk);
    req_mode <= m;
    req_op <= o;
    req_reg <= r;
    req_two <= a;
    req_bit_hi <= a;
    instr_b2 <= b2;
    {instr_b3, instr_b4} <= w;
    pc_next <= w;
    req_valid <= 1'b1;
    #1;
    while (!req_ready) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
  endtask
  task automatic t_post_inc;
    wr(3'h1, 16'h1000);
    wr(3'h2, 16'h2ffe);
    req(3'h0, 4'h0, 3'h1, 1'b0, 8'h00, 16'h0);
    got("post byte", 4'h8, 16'h1000, ea_addr);
    rd(3'h1, 16'h1001);
    req(3'h0, 4'h2, 3'h2, 1'b0, 8'h00, 16'h0);
    got("post word", 4'h8, 16'h2ffe, ea_addr);
    rd(3'h2, 16'h3000);
  endtask
  task automatic t_pre_dec;
    wr(3'h3, 16'h0001);
    req(3'h1, 4'h1, 3'h3, 1'b0, 8'h00, 16'h0);
    got("pre byte", 4'h8, 16'h0000, ea_addr);
    rd(3'h3, 16'h0000);
    req(3'h1, 4'h3, 3'h3, 1'b0, 8'h00, 16'h0);
    got("pre word", 4'h8, 16'hfffe, ea_addr);
    rd(3'h3, 16'hfffe);
  endtask
  task automatic t_refuse;
    logic [6:0] bad [10] = '{7'h01, 7'h03, 7'h10, 7'h12, 7'h25, 7'h50, 7'h34, 7'h60, 7'h70,
                             7'h4f};
    wr(3'h4, 16'h0100);
    foreach (bad[i]) begin
      req(bad[i][6:4], bad[i][3:0], 3'h4, 1'b0, 8'h20, 16'h0);
      check("refused", {12'h0, pl}, 16'h0001);
    end
    rd(3'h4, 16'h0100);
  endtask
  task automatic t_abs;
    logic [3:0] ops [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
    req(3'h2, 4'h0, 3'h0, 1'b0, 8'h00, 16'h0);
    got("short abs", 4'h8, 16'hff00, ea_addr);
    req(3'h2, 4'h4, 3'h0, 1'b0, 8'hff, 16'h0);
    got("short bit", 4'ha, 16'hffff, ea_addr);
    check("bit number", {13'h0, bit_num}, 16'h0007);
    foreach (ops[i]) begin
      req(3'h3, ops[i], 3'h0, 1'b0, 8'h00, {12'hbe0, ops[i]});
      got("long abs", 4'h8, {12'hbe0, ops[i]}, ea_addr);
    end
  endtask
  task automatic t_imm;
    req(3'h4, 4'h0, 3'h0, 1'b0, 8'ha5, 16'h0);
    got("short imm", 4'h4, 16'h00a5, imm_data);
    req(3'h5, 4'h2, 3'h0, 1'b0, 8'h00, 16'h1234);
    got("long imm", 4'h4, 16'h1234, imm_data);
    req(3'h4, 4'h4, 3'h0, 1'b1, 8'h00, 16'h0050);
    got("bit imm", 4'h6, 16'h0000, imm_data);
    check("bit high", {13'h0, bit_num}, 16'h0005);
    for (int k = 0; k < 4; k++) begin
      req(3'h4, k[1] ? 4'ha : 4'h9, 3'h0, k[0], 8'h00, 16'h0);
      got("step", 4'h4, k[0] ? 16'h0002 : 16'h0001, imm_data);
    end
  endtask
  task automatic t_branch;
    req(3'h6, 4'h7, 3'h0, 1'b0, 8'h7e, 16'h4002);
    got("branch fwd", 4'h8, 16'h4080, ea_addr);
    req(3'h6, 4'h8, 3'h0, 1'b0, 8'h80, 16'h4002);
    got("branch back", 4'h8, 16'h3f82, ea_addr);
  endtask
  task automatic t_mem_ind(input s, input [3:0] o, input [7:0] a, input [15:0] e);
    @(posedge mclk);
    slow <= s;
    req(3'h7, o, 3'h0, 1'b0, a, 16'h0);
    repeat (40) if (ea_valid !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    got("indirect", 4'h8, e, ea_addr);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst, req_valid, req_two, req_bit_hi, ex_we, slow} = 6'h20;
    {req_mode, req_reg, ex_sel, rd_sel, req_op} = '0;
    {instr_b2, instr_b3, instr_b4, pc_next, ex_data} = '0;
    err_count = 0;
    n_tests = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_post_inc;
    t_pre_dec;
    t_refuse;
    t_abs;
    t_imm;
    t_branch;
    t_mem_ind(1'b0, 4'h5, 8'h10, 16'h4a4b);
    t_mem_ind(1'b1, 4'h6, 8'hff, 16'ha55a);
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    report_and_stop;
  end
endmodule // ceau_unit_test
bind ceau_unit ceau_unit_properties chk (.mclk, .rst, .req_valid, .req_ready, .req_mode,
  .req_op, .req_two, .instr_b2, .instr_b3, .instr_b4, .pc_next, .mem_rd, .mem_addr,
  .ea_valid, .ea_addr, .imm_valid, .imm_data, .ea_illegal);
